// *** verilog/ptr_pkg.sv ***
// Constants for the port-three and reset-pin block
// Functional notes
// R1: Reset pin high for sixteen core clocks while running resets the device.
// R2: Pin with port bit one is weakly pulled high and usable as input.
// R3: Rising output edge turns on strong pull-up for exactly one core clock.
// R4: Pin zero carries UART receive data into the core.
// R5: Pin one carries UART transmit data out when enabled.
// R6: Pin two is external interrupt zero and timer zero gate.
// R7: Pin three is external interrupt one and timer one gate.
// R8: Pin four is timer zero external count input.
// R9: Pin five is timer one external count input.
// R10: Pin six drives external data memory write strobe.
// R11: Pin seven drives external data memory read strobe.
// R12: Pin with port bit zero and no override is driven low.
package ptr_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int unsigned PORT_WIDTH       = 8;
    localparam int unsigned RESET_HOLD_CYC   = 16;
    localparam int unsigned RESET_CNT_W      = 5;
    localparam logic [7:0]  LATCH_RESET      = 8'hff;
    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int unsigned PIN_RXD   = 0;
    localparam int unsigned PIN_TXD   = 1;
    localparam int unsigned PIN_IRQ0  = 2;
    localparam int unsigned PIN_IRQ1  = 3;
    localparam int unsigned PIN_CNT0  = 4;
    localparam int unsigned PIN_CNT1  = 5;
    localparam int unsigned PIN_WRN   = 6;
    localparam int unsigned PIN_RDN   = 7;
endpackage : ptr_pkg

// *** verilog/ptr_sync.sv ***
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ptr_sync #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // Next values; first stage feeds only the second
    always_comb begin
        next_stage1   = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    // Registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // ptr_sync
`default_nettype wire

// *** verilog/ptr_port3.sv ***
// Port-three pin logic with alternate functions and reset-pin filter
`timescale 1ns/1ps
`default_nettype none
module ptr_port3 #(
    parameter int unsigned WIDTH = ptr_pkg::PORT_WIDTH
) (
    // Clock, reset and enable
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    // External reset pin
    input  wire logic             reset_pin,
    output logic                  core_reset_req,
    // Core port latch interface
    input  wire logic             latch_we,
    input  wire logic [WIDTH-1:0] latch_wdata,
    output logic      [WIDTH-1:0] latch_q,
    output logic      [WIDTH-1:0] pin_state,
    // Alternate function controls from the core
    input  wire logic             uart_tx_en,
    input  wire logic             uart_txd,
    input  wire logic             xmem_wr_active,
    input  wire logic             xmem_rd_active,
    // Alternate function inputs to the core
    output logic                  uart_rxd,
    output logic                  external_irq_zero,
    output logic                  external_irq_one,
    output logic                  timer_zero_count_input,
    output logic                  timer_one_count_input,
    // Pins: input, driven level, enable low while driving, strong pull-up
    input  wire logic [WIDTH-1:0] port_three_pins_in,
    output logic      [WIDTH-1:0] port_three_pins_out,
    output logic      [WIDTH-1:0] port_three_pins_oe_n,
    output logic      [WIDTH-1:0] port_three_pins_strong
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [WIDTH:0] sync_q;

    ptr_sync #(
        .WIDTH (WIDTH + 1)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in ({reset_pin, port_three_pins_in}),
        .sync_out (sync_q)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [ptr_pkg::RESET_CNT_W-1:0] hold_cnt;
    logic [ptr_pkg::RESET_CNT_W-1:0] next_hold_cnt;
    logic                            next_core_reset_req;
    logic [WIDTH-1:0]                next_latch_q;
    logic [WIDTH-1:0]                drive_level;
    logic [WIDTH-1:0]                prev_level;
    logic [WIDTH-1:0]                next_prev_level;
    logic [WIDTH-1:0]                next_pins_out;
    logic [WIDTH-1:0]                next_pins_oe_n;
    logic [WIDTH-1:0]                next_pins_strong;
    logic [WIDTH-1:0]                next_pin_state;
    logic                            next_uart_rxd;
    logic                            next_irq0;
    logic                            next_irq1;
    logic                            next_cnt0;
    logic                            next_cnt1;

    // Effective level per pin: latch, ANDed with transmit data or forced low by the strobes
    always_comb begin
        drive_level = latch_q;
        if (uart_tx_en) begin
            drive_level[ptr_pkg::PIN_TXD] = latch_q[ptr_pkg::PIN_TXD] & uart_txd; // R5
        end
        if (xmem_wr_active) begin
            drive_level[ptr_pkg::PIN_WRN] = 1'b0; // R10
        end
        if (xmem_rd_active) begin
            drive_level[ptr_pkg::PIN_RDN] = 1'b0; // R11
        end
    end

    // Next values of the reset filter, latch and pin drivers
    always_comb begin
        next_hold_cnt       = hold_cnt;
        next_core_reset_req = core_reset_req;
        next_latch_q        = latch_q;
        next_prev_level     = prev_level;
        next_pins_out       = port_three_pins_out;
        next_pins_oe_n      = port_three_pins_oe_n;
        next_pins_strong    = port_three_pins_strong;
        next_pin_state      = pin_state;
        next_uart_rxd       = uart_rxd;
        next_irq0           = external_irq_zero;
        next_irq1           = external_irq_one;
        next_cnt0           = timer_zero_count_input;
        next_cnt1           = timer_one_count_input;
        if (clk_en) begin
            // Reset request only after sixteen high samples; glitches restart count
            if (!sync_q[WIDTH]) begin
                next_hold_cnt       = '0; // R1
                next_core_reset_req = 1'b0;
            end else if (hold_cnt < ptr_pkg::RESET_CNT_W'(ptr_pkg::RESET_HOLD_CYC)) begin
                next_hold_cnt = hold_cnt + 1'b1; // R1
            end
            if (sync_q[WIDTH] && hold_cnt >= ptr_pkg::RESET_CNT_W'(ptr_pkg::RESET_HOLD_CYC - 1)) begin
                next_core_reset_req = 1'b1; // R1
            end
            if (latch_we) begin
                next_latch_q = latch_wdata;
            end
            // High is weak pull-up only, low is driven
            next_pins_out    = '0;
            next_pins_oe_n   = ~(~drive_level); // R2 R12
            // One-clock strong pull-up on each rising output edge
            next_pins_strong = drive_level & ~prev_level; // R3
            next_prev_level  = drive_level;
            next_pin_state   = sync_q[WIDTH-1:0]; // R2
            next_uart_rxd    = sync_q[ptr_pkg::PIN_RXD]; // R4
            next_irq0        = sync_q[ptr_pkg::PIN_IRQ0]; // R6
            next_irq1        = sync_q[ptr_pkg::PIN_IRQ1]; // R7
            next_cnt0        = sync_q[ptr_pkg::PIN_CNT0]; // R8
            next_cnt1        = sync_q[ptr_pkg::PIN_CNT1]; // R9
        end
    end

    // Registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_cnt               <= '0;
            core_reset_req         <= 1'b0;
            latch_q                <= ptr_pkg::LATCH_RESET;
            prev_level             <= ptr_pkg::LATCH_RESET;
            port_three_pins_out    <= '0;
            port_three_pins_oe_n   <= '1;
            port_three_pins_strong <= '0;
            pin_state              <= '0;
            uart_rxd               <= 1'b0;
            external_irq_zero      <= 1'b0;
            external_irq_one       <= 1'b0;
            timer_zero_count_input <= 1'b0;
            timer_one_count_input  <= 1'b0;
        end else begin
            hold_cnt               <= next_hold_cnt;
            core_reset_req         <= next_core_reset_req;
            latch_q                <= next_latch_q;
            prev_level             <= next_prev_level;
            port_three_pins_out    <= next_pins_out;
            port_three_pins_oe_n   <= next_pins_oe_n;
            port_three_pins_strong <= next_pins_strong;
            pin_state              <= next_pin_state;
            uart_rxd               <= next_uart_rxd;
            external_irq_zero      <= next_irq0;
            external_irq_one       <= next_irq1;
            timer_zero_count_input <= next_cnt0;
            timer_one_count_input  <= next_cnt1;
        end
    end
endmodule // ptr_port3
`default_nettype wire

// *** tb/ptr_port3_asserts.sv ***
// Assertion checker for the port-three block
`timescale 1ns/1ps
`default_nettype none
module ptr_port3_chk #(
    parameter int unsigned WIDTH = 8
) (
    // Clock, reset and controls (grouped to keep the checker short)
    input wire logic clk_sys, resetn, clk_en, reset_pin, core_reset_req,
    input wire logic uart_tx_en, uart_txd, xmem_wr_active, xmem_rd_active,
    // Alternate inputs toward the core
    input wire logic uart_rxd, external_irq_zero, external_irq_one,
    input wire logic timer_zero_count_input, timer_one_count_input,
    // Latch and pins
    input wire logic [WIDTH-1:0] latch_q, port_three_pins_in,
    input wire logic [WIDTH-1:0] port_three_pins_oe_n, port_three_pins_strong
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !clk_en);
    wire logic [WIDTH-1:0] oe  = port_three_pins_oe_n;
    wire logic [WIDTH-1:0] pin = port_three_pins_in;
    logic [1:0] up, d;
    logic [4:0] hi;
    // Mirror of the pin sync so counts line up; warm-up hides the pipe flush
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            up <= 2'h0;
            d  <= 2'h0;
            hi <= 5'h00;
        end else begin
            up <= (up == 2'h3) ? up : up + 2'h1;
            d  <= {d[0], reset_pin};
            hi <= !d[1] ? 5'h00 : (hi == 5'h1f) ? hi : hi + 5'h01;
        end
    end
    a_plain_follow: assert property ({oe[5:2], oe[0]} == $past({latch_q[5:2], latch_q[0]}))
        else $error("plain pin enable does not follow latch");
    a_strong_pulse: assert property (port_three_pins_strong == (oe & ~$past(oe)))
        else $error("strong pull-up not exactly on release");
    a_wr_strobe: assert property (xmem_wr_active |=> !oe[6])
        else $error("write strobe not driven");
    a_rd_strobe: assert property (xmem_rd_active |=> !oe[7])
        else $error("read strobe not driven");
    a_tx_level: assert property (uart_tx_en && latch_q[1] |=> oe[1] == $past(uart_txd))
        else $error("transmit pin wrong");
    a_alt_sync: assert property (up == 2'h3 |-> {timer_one_count_input,
        timer_zero_count_input, external_irq_one, external_irq_zero, uart_rxd}
        == $past({pin[5:2], pin[0]}, 3)) else $error("alternate input wrong");
    a_reset_rise: assert property ($rose(core_reset_req) |-> hi inside {[16:17]})
        else $error("reset request at wrong count");
    a_reset_drop: assert property (!reset_pin [*4] |=> !core_reset_req)
        else $error("reset request stays after pin low");
    c_reset_seen: cover property ($rose(core_reset_req));
    c_strong_seen: cover property (|port_three_pins_strong);
    c_wr_done: cover property (xmem_wr_active ##1 !xmem_wr_active);
endmodule // ptr_port3_chk
bind ptr_port3 ptr_port3_chk #(.WIDTH(WIDTH)) ptr_port3_chk_i (.*);
`default_nettype wire

// *** tb/ptr_far_end.sv ***
// Far-side model: pin wiring, outside drivers and external memory strobes
`timescale 1ns/1ps
`default_nettype none
module ptr_far_end (
    // Device enables and outside drivers
    input wire logic [7:0] oe_n, ext_en, ext_val,
    // Resolved pin levels and strobe counts
    output logic     [7:0] pins,
    output var logic [7:0] wr_count, rd_count
);
    // Device low wins, then an outside driver, else the weak pull-up
    assign pins = oe_n & (~ext_en | ext_val);
    initial {wr_count, rd_count} = 16'h0000;
    // Memory latches the port-zero byte as the write strobe ends; skip time-zero edges
    always @(posedge pins[6]) if ($time > 0) wr_count <= wr_count + 8'h01;
    // Memory puts its byte on port zero once the read strobe falls
    always @(negedge pins[7]) if ($time > 0) rd_count <= rd_count + 8'h01;
endmodule // ptr_far_end
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the port-three block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, resetn, clk_en, reset_pin, core_reset_req, latch_we, uart_rxd, uart_tx_en;
    logic uart_txd, xmem_wr_active, xmem_rd_active, external_irq_zero, external_irq_one;
    logic timer_zero_count_input, timer_one_count_input;
    logic [7:0] latch_wdata, latch_q, pin_state, port_three_pins_in, port_three_pins_out;
    logic [7:0] port_three_pins_oe_n, port_three_pins_strong, ext_en, ext_val, wr_c, rd_c;
    int bad_count, num_checks, cycles;
    ptr_port3 ptr_port3_i (.*);
    ptr_far_end ptr_far_end_i (.oe_n(port_three_pins_oe_n), .ext_en(ext_en), .ext_val(ext_val),
        .pins(port_three_pins_in), .wr_count(wr_c), .rd_count(rd_c));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Run needs about 134 cycles; a hang ends here
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] v);
        latch_wdata = v;
        latch_we = 1'b1;
        cyc(1);
        latch_we = 1'b0;
    endtask
    // Each pin driven low, then released with one strong cycle
    task automatic t_latch;
        for (int k = 0; k < 8; k++) begin
            put(~(8'h01 << k));
            cyc(2);
            chk(port_three_pins_in, ~(8'h01 << k));
            put(8'hff);
            cyc(1);
            chk(port_three_pins_strong, 8'h01 << k);
            cyc(1);
            chk(port_three_pins_strong | ~port_three_pins_in, 8'h00);
        end
    endtask
    // Outside drives the input pins; alternate inputs follow after the sync
    task automatic t_inputs;
        for (int i = 0; i < 2; i++) begin
            ext_en = 8'h3d;
            ext_val = i ? 8'h2a : 8'h15;
            cyc(4);
            chk({3'h0, timer_one_count_input, timer_zero_count_input,
                external_irq_one, external_irq_zero, uart_rxd}, {ext_val[5:2], ext_val[0]});
            chk(pin_state, ext_val | 8'hc2);
        end
        ext_en = 8'h00;
    endtask
    task automatic t_tx;
        uart_tx_en = 1'b1;
        cyc(2);
        chk(port_three_pins_in, 8'hfd);
        uart_txd = 1'b1;
        cyc(1);
        chk(port_three_pins_strong, 8'h02);
        uart_tx_en = 1'b0;
    endtask
    // Back-to-back write then read strobe
    task automatic t_xmem;
        logic [7:0] w, r;
        w = wr_c;
        r = rd_c;
        xmem_wr_active = 1'b1;
        cyc(3);
        chk(port_three_pins_in, 8'hbf);
        xmem_wr_active = 1'b0;
        xmem_rd_active = 1'b1;
        cyc(3);
        chk(port_three_pins_in, 8'h7f);
        xmem_rd_active = 1'b0;
        cyc(2);
        chk({wr_c[3:0] - w[3:0], rd_c[3:0] - r[3:0]}, 8'h11);
    endtask
    // Enable low freezes the latch; a write while frozen must be lost
    task automatic t_freeze;
        clk_en = 1'b0;
        put(8'h00);
        cyc(3);
        clk_en = 1'b1;
        cyc(2);
        chk(latch_q, 8'hff);
        chk(port_three_pins_in, 8'hff);
        chk(port_three_pins_out, 8'h00);
    endtask
    // One sample short of the filter, then a full hold
    task automatic t_rst(input int n, input logic [7:0] exp);
        reset_pin = 1'b1;
        cyc(n);
        chk({7'h00, core_reset_req}, exp);
        reset_pin = 1'b0;
        cyc(5);
        chk({7'h00, core_reset_req}, 8'h00);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {resetn, reset_pin, latch_we, uart_tx_en, uart_txd, xmem_wr_active} = 6'h00;
        {xmem_rd_active, ext_en, ext_val, latch_wdata} = 25'h0_0000;
        clk_en = 1'b1;
        cyc(12);
        resetn = 1'b1;
        cyc(2);
        t_latch();
        t_inputs();
        t_tx();
        t_xmem();
        t_freeze();
        t_rst(15, 8'h00);
        t_rst(22, 8'h01);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
